// ---- hdl/nobox_core.sv ----
// Executor for the no-operation and byte OR instruction forms
//
// Function
// [RL1] Opcode 00h: one byte, one cycle, only the program counter advances.
// [RL2] Byte OR writes operand OR into destination; no flag is touched.
// [RL3] Six OR forms: A with reg/direct/indirect/immediate; direct with A/immediate.
// [RL4] OR into an output port reads the port latch, not the pins.
// [RL5] Direct-destination OR sets any bits in RAM, the accumulator or the port latches.
// [RL6] Opcode 01001rrr ORs a bank register into A; one byte, one cycle.
// [RL7] Opcode 45h plus address ORs a direct byte into A; two bytes, one cycle.
// [RL8] Opcode 0100011i ORs pointer-addressed RAM into A; one byte, one cycle.
// [RL9] Opcode 44h plus data ORs immediate into A; two bytes, one cycle.
// [RL10] Opcode 43h, address, data ORs immediate into direct; three bytes, two cycles.
// [RL11] Opcode 42h plus address ORs A into direct byte; two bytes, one cycle.
`timescale 1ns/100ps
`include "nobox_regs.svh"

module nobox_core
    import nobox_pkg::*;
#(
    parameter int RAM_DEPTH = 128
) (
    input wire logic i_ref_clk,               // Machine-cycle clock, 25 MHz
    input wire logic i_reset_n,               // Synchronous reset, active low
    input wire nobox_instr_s i_instr,         // Opcode and operand bytes
    input wire logic [1:0] i_bank,            // Working register bank select
    input wire logic [3:0][7:0] i_port_pins,  // Port pin levels
    output logic o_ready,                     // Instruction can be taken
    output logic o_done,                      // Instruction completed pulse
    output logic o_illegal,                   // Unsupported opcode pulse
    output logic [15:0] o_pc,                 // Program counter
    output logic [7:0] o_acc,                 // Accumulator
    output logic [3:0][7:0] o_port_latch      // Port output latches
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    nobox_state_s state_reg;
    nobox_state_s state_next;
    logic take;
    logic [7:0] src_val;
    logic [7:0] rmw_val;
    logic [7:0] ptr_val;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_val;

    assign o_ready = (state_reg.phase == NOBOX_EXEC);
    assign take = i_instr.valid && o_ready;
    assign o_done = state_reg.done;
    assign o_illegal = state_reg.illegal;
    assign o_pc = state_reg.pc;
    assign o_acc = state_reg.acc;
    assign o_port_latch = state_reg.port;

    // ----------------------------------------------------------------
    // Data space read
    // ----------------------------------------------------------------
    // Ports answer from the latch on read-modify-write, from pins otherwise
    function automatic logic [7:0] rd_direct(input nobox_state_s s,
                                             input logic [3:0][7:0] pins,
                                             input logic [7:0] a,
                                             input logic rmw);
        logic [7:0] v;
        v = 8'h00;
        if (a < `NOBOX_SFR_BASE) begin
            v = s.ram[a[6:0]];
        end else if (a == `NOBOX_ADDR_ACC) begin
            v = s.acc;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (a == 8'(`NOBOX_ADDR_P0 + 8'(k) * `NOBOX_PORT_STEP)) begin
                    v = rmw ? s.port[k] : pins[k]; // see [RL4]
                end
            end
        end
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Operand selection
    // ----------------------------------------------------------------
    always_comb begin
        ptr_val = state_reg.ram[{2'b00, i_bank, 2'b00, i_instr.op[0]}];
        src_val = 8'h00;
        rmw_val = rd_direct(state_reg, i_port_pins, i_instr.b1, 1'b1);
        if (i_instr.op[7:3] == `NOBOX_OP_BANK_HI) begin
            src_val = state_reg.ram[{2'b00, i_bank, i_instr.op[2:0]}]; // see [RL6]
        end else if (i_instr.op[7:1] == `NOBOX_OP_IND_HI) begin
            // Indirect reach is internal RAM only; the top address bit is dropped
            src_val = state_reg.ram[ptr_val[6:0]]; // see [RL8]
        end else if (i_instr.op == `NOBOX_OP_DIR) begin
            src_val = rd_direct(state_reg, i_port_pins, i_instr.b1, 1'b0); // see [RL7]
        end else if (i_instr.op == `NOBOX_OP_IMM) begin
            src_val = i_instr.b1; // see [RL9]
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.illegal = 1'b0;
        wr_en = 1'b0;
        wr_addr = 8'h00;
        wr_val = 8'h00;
        unique case (state_reg.phase)
            NOBOX_EXEC: begin
                if (take) begin
                    state_next.done = 1'b1;
                    state_next.pc = state_reg.pc + `NOBOX_LEN_1;
                    if (i_instr.op == `NOBOX_OP_NO_OPERATION) begin
                        state_next.pc = state_reg.pc + `NOBOX_LEN_1; // see [RL1]
                    end else if (i_instr.op[7:3] == `NOBOX_OP_BANK_HI ||
                                 i_instr.op[7:1] == `NOBOX_OP_IND_HI) begin
                        state_next.acc = state_reg.acc | src_val; // see [RL2] see [RL3]
                    end else if (i_instr.op == `NOBOX_OP_DIR ||
                                 i_instr.op == `NOBOX_OP_IMM) begin
                        state_next.acc = state_reg.acc | src_val; // see [RL2]
                        state_next.pc = state_reg.pc + `NOBOX_LEN_2; // see [RL7] see [RL9]
                    end else if (i_instr.op == `NOBOX_OP_DIR_A) begin
                        wr_en = 1'b1; // see [RL11] see [RL5]
                        wr_addr = i_instr.b1;
                        wr_val = rmw_val | state_reg.acc;
                        state_next.pc = state_reg.pc + `NOBOX_LEN_2;
                    end else if (i_instr.op == `NOBOX_OP_DIR_IMM) begin
                        // Result held one cycle; written in the second machine cycle
                        state_next.done = 1'b0; // see [RL10]
                        // Counter moves once, by three, in the write cycle
                        state_next.pc = state_reg.pc;
                        state_next.phase = NOBOX_WRITE;
                        state_next.wb_addr = i_instr.b1;
                        state_next.wb_data = rmw_val | i_instr.b2; // see [RL5]
                    end else begin
                        // Unknown opcodes are skipped as one byte
                        state_next.illegal = 1'b1;
                    end
                end
            end
            NOBOX_WRITE: begin
                wr_en = 1'b1;
                wr_addr = state_reg.wb_addr;
                wr_val = state_reg.wb_data;
                state_next.phase = NOBOX_EXEC;
                state_next.done = 1'b1;
                state_next.pc = state_reg.pc + `NOBOX_LEN_3; // see [RL10]
            end
        endcase
        if (wr_en) begin
            if (wr_addr < `NOBOX_SFR_BASE) begin
                state_next.ram[wr_addr[6:0]] = wr_val;
            end else if (wr_addr == `NOBOX_ADDR_ACC) begin
                state_next.acc = wr_val;
            end else begin
                for (int k = 0; k < 4; k++) begin
                    if (wr_addr == 8'(`NOBOX_ADDR_P0 + 8'(k) * `NOBOX_PORT_STEP)) begin
                        state_next.port[k] = wr_val; // see [RL4]
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Register
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            state_reg.phase <= NOBOX_EXEC;
            state_reg.pc <= `NOBOX_RST_PC;
            state_reg.acc <= `NOBOX_RST_ACC;
            state_reg.port <= {4{`NOBOX_RST_PORT}};
            state_reg.ram <= {128{`NOBOX_RST_RAM}};
            state_reg.wb_addr <= 8'h00;
            state_reg.wb_data <= 8'h00;
            state_reg.done <= 1'b0;
            state_reg.illegal <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    // Pointer register chosen by opcode bit 0 inside the selected bank
    logic [7:0] ptr_expect;
    assign ptr_expect = state_reg.ram[{2'b00, i_bank, 2'b00, i_instr.op[0]}];

    sequence s_issue(logic [7:0] opc);
        take && i_instr.op == opc;
    endsequence

    sequence s_two_cycle;
        s_issue(`NOBOX_OP_DIR_IMM) ##1 (!o_ready && !o_done) ##1 (o_ready && o_done);
    endsequence

    property p_no_op;
        s_issue(`NOBOX_OP_NO_OPERATION) |=> o_done && o_pc == $past(o_pc) + 16'h0001 &&
            $stable(o_acc) && $stable(o_port_latch) && $stable(state_reg.ram);
    endproperty
    a_no_op: assert property (p_no_op) else $error("idle opcode changed more than pc"); // see [RL1]

    property p_imm;
        s_issue(`NOBOX_OP_IMM) |=> o_acc == ($past(o_acc) | $past(i_instr.b1)) &&
            o_pc == $past(o_pc) + 16'h0002;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate or wrong"); // see [RL9]

    property p_reg;
        take && i_instr.op[7:3] == 5'h09 |=> o_done && o_pc == $past(o_pc) + 16'h0001 &&
            o_acc == ($past(o_acc) | $past(state_reg.ram[{2'b00, i_bank, i_instr.op[2:0]}]));
    endproperty
    a_reg: assert property (p_reg) else $error("register or wrong"); // see [RL6]

    property p_dir;
        s_issue(`NOBOX_OP_DIR) |=> o_done && o_acc == $past(o_acc | src_val) &&
            o_pc == $past(o_pc) + 16'h0002;
    endproperty
    a_dir: assert property (p_dir) else $error("direct or wrong"); // see [RL7]

    property p_ind;
        take && i_instr.op[7:1] == 7'h23 |=> o_done && o_pc == $past(o_pc) + 16'h0001 &&
            o_acc == ($past(o_acc) | $past(state_reg.ram[ptr_expect[6:0]]));
    endproperty
    a_ind: assert property (p_ind) else $error("indirect or wrong"); // see [RL8]

    property p_two;
        s_issue(`NOBOX_OP_DIR_IMM) |-> s_two_cycle;
    endproperty
    a_two: assert property (p_two) else $error("direct immediate timing wrong"); // see [RL10]

    property p_two_pc;
        s_issue(`NOBOX_OP_DIR_IMM) |-> ##2 o_pc == $past(o_pc, 2) + 16'h0003;
    endproperty
    a_two_pc: assert property (p_two_pc) else $error("three byte pc wrong"); // see [RL10]

    property p_port_latch;
        s_issue(`NOBOX_OP_DIR_A) ##0 i_instr.b1 == 8'h90 |=>
            o_port_latch[1] == ($past(o_port_latch[1]) | $past(o_acc));
    endproperty
    a_port_latch: assert property (p_port_latch) else $error("port or used pins"); // see [RL4]

    property p_ram_imm;
        s_issue(`NOBOX_OP_DIR_IMM) ##0 i_instr.b1 < 8'h80 |-> ##2
            state_reg.ram[$past(i_instr.b1[6:0], 2)] ==
            ($past(state_reg.ram[i_instr.b1[6:0]], 2) | $past(i_instr.b2, 2)) &&
            $stable(o_acc);
    endproperty
    a_ram_imm: assert property (p_ram_imm) else $error("ram mask set wrong"); // see [RL5]

    property p_dir_a;
        s_issue(`NOBOX_OP_DIR_A) |=> o_done && o_pc == $past(o_pc) + 16'h0002;
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("direct acc timing wrong"); // see [RL11]

    // RAM destination of 42h gets the accumulator ORed in, read from the RAM itself
    property p_dir_a_ram;
        s_issue(`NOBOX_OP_DIR_A) ##0 i_instr.b1 < 8'h80 |=>
            state_reg.ram[$past(i_instr.b1[6:0])] ==
            ($past(state_reg.ram[i_instr.b1[6:0]]) | $past(o_acc));
    endproperty
    a_dir_a_ram: assert property (p_dir_a_ram) else $error("direct acc mask wrong"); // see [RL5]

    property p_dir_ram;
        s_issue(`NOBOX_OP_DIR) ##0 i_instr.b1 < 8'h80 |=>
            o_acc == ($past(o_acc) | $past(state_reg.ram[i_instr.b1[6:0]]));
    endproperty
    a_dir_ram: assert property (p_dir_ram) else $error("direct ram source wrong"); // see [RL7]

    // A plain read of a port sees the pins; only read-modify-write forms use the latch
    property p_dir_pins;
        s_issue(`NOBOX_OP_DIR) ##0 i_instr.b1 == 8'ha0 |=>
            o_acc == ($past(o_acc) | $past(i_port_pins[2]));
    endproperty
    a_dir_pins: assert property (p_dir_pins) else $error("direct port source wrong"); // see [RL7]

    property p_port_imm;
        s_issue(`NOBOX_OP_DIR_IMM) ##0 i_instr.b1 == 8'h90 |-> ##2
            o_port_latch[1] == ($past(o_port_latch[1], 2) | $past(i_instr.b2, 2));
    endproperty
    a_port_imm: assert property (p_port_imm) else $error("port mask used pins"); // see [RL4]

    // The counter must not move in the first of the two cycles, or 43h skips a byte
    property p_pc_hold;
        s_issue(`NOBOX_OP_DIR_IMM) |=> $stable(o_pc) && $stable(o_acc);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved in first cycle"); // see [RL10]

    property p_stall_one;
        !o_ready |=> o_ready;
    endproperty
    a_stall_one: assert property (p_stall_one) else $error("ready low too long"); // see [RL10]

    // A skipped opcode behaves like one byte of nothing
    property p_illegal;
        o_illegal |-> o_pc == $past(o_pc) + 16'h0001 && $stable(o_acc) &&
            $stable(o_port_latch) && $stable(state_reg.ram);
    endproperty
    a_illegal: assert property (p_illegal) else $error("skipped opcode changed state"); // see [RL3]

endmodule // nobox_core

// ---- hdl/nobox_regs.svh ----
// Opcodes, lengths, data-space addresses and reset values
`ifndef NOBOX_REGS_SVH
`define NOBOX_REGS_SVH

`define NOBOX_OP_NO_OPERATION 8'h00
`define NOBOX_OP_BANK_HI 5'h09
`define NOBOX_OP_IND_HI 7'h23
`define NOBOX_OP_DIR 8'h45
`define NOBOX_OP_IMM 8'h44
`define NOBOX_OP_DIR_A 8'h42
`define NOBOX_OP_DIR_IMM 8'h43

`define NOBOX_LEN_1 16'h0001
`define NOBOX_LEN_2 16'h0002
`define NOBOX_LEN_3 16'h0003

`define NOBOX_SFR_BASE 8'h80
`define NOBOX_ADDR_ACC 8'he0
`define NOBOX_ADDR_P0 8'h80
`define NOBOX_PORT_STEP 8'h10

`define NOBOX_RST_PC 16'h0000
`define NOBOX_RST_ACC 8'h00
`define NOBOX_RST_PORT 8'hff
`define NOBOX_RST_RAM 8'h00

`endif

// ---- hdl/nobox_pkg.sv ----
// Types shared by the OR / no-operation executor
package nobox_pkg;

    typedef enum logic {
        NOBOX_EXEC,
        NOBOX_WRITE
    } nobox_phase_e;

    typedef struct packed {
        logic valid;
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
    } nobox_instr_s;

    typedef struct packed {
        nobox_phase_e phase;
        logic [15:0] pc;
        logic [7:0] acc;
        logic [3:0][7:0] port;
        logic [127:0][7:0] ram;
        logic [7:0] wb_addr;
        logic [7:0] wb_data;
        logic done;
        logic illegal;
    } nobox_state_s;

endpackage

// ---- tb/nobox_core_bench.sv ----
// Self-checking bench for the no-operation and byte OR executor
`timescale 1ns/100ps

module nobox_core_bench;
    import nobox_pkg::*;

    logic i_ref_clk;
    logic i_reset_n;
    nobox_instr_s i_instr;
    logic [1:0] i_bank;
    logic [3:0][7:0] i_port_pins;
    logic o_ready;
    logic o_done;
    logic o_illegal;
    logic [15:0] o_pc;
    logic [7:0] o_acc;
    logic [3:0][7:0] o_port_latch;
    int error_cnt = 0;
    int n_checks = 0;
    logic [15:0] exp_pc;

    nobox_core u_nobox_core (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_instr(i_instr),
        .i_bank(i_bank),
        .i_port_pins(i_port_pins),
        .o_ready(o_ready),
        .o_done(o_done),
        .o_illegal(o_illegal),
        .o_pc(o_pc),
        .o_acc(o_acc),
        .o_port_latch(o_port_latch)
    );

    // ---------------------------------------------------------------
    // Clock, verdict and comparison helpers
    // ---------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    task automatic test_done();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One instruction; the 43h form also offers a request while not ready, which must be ignored
    task automatic exec(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                        input int len, input bit two);
        @(posedge i_ref_clk);
        i_instr <= '{valid: 1'b1, op: op, b1: b1, b2: b2};
        @(posedge i_ref_clk);
        if (two) begin
            i_instr <= '{valid: 1'b1, op: 8'h44, b1: 8'hff, b2: 8'h00};
            #1;
            chk({o_ready, o_done}, 16'h0000);
            @(posedge i_ref_clk);
        end
        i_instr.valid <= 1'b0;
        #1;
        chk({o_ready, o_done, o_illegal}, 16'h0006);
        exp_pc = exp_pc + 16'(len);
        chk(o_pc, exp_pc);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk({o_ready, o_done, o_illegal}, 16'h0004);
        chk(o_pc, 16'h0000);
        chk(o_acc, 16'h0000);
        for (int p = 0; p < 4; p++) begin
            chk(o_port_latch[p], 16'h00ff);
        end
    endtask

    task automatic t_nop_imm();
        exec(8'h00, 8'h44, 8'h77, 1, 1'b0);
        chk(o_acc, 16'h0000);
        exec(8'h44, 8'h01, 8'h00, 2, 1'b0);
        chk(o_acc, 16'h0001);
    endtask

    // Bank 1 register 3 lives at RAM 0bh; the refused OR of ffh must not reach the accumulator
    task automatic t_bank_reg();
        exec(8'h43, 8'h0b, 8'h80, 3, 1'b1);
        chk(o_acc, 16'h0001);
        exec(8'h4b, 8'h00, 8'h00, 1, 1'b0);
        chk(o_acc, 16'h0081);
    endtask

    // Pointer register 1 of bank 1 sits at RAM 09h and points at 20h
    task automatic t_indirect();
        exec(8'h43, 8'h09, 8'h20, 3, 1'b1);
        exec(8'h43, 8'h20, 8'h04, 3, 1'b1);
        exec(8'h47, 8'h00, 8'h00, 1, 1'b0);
        chk(o_acc, 16'h0085);
    endtask

    task automatic t_direct();
        exec(8'h43, 8'h30, 8'h40, 3, 1'b1);
        exec(8'h42, 8'h30, 8'h00, 2, 1'b0);
        chk(o_acc, 16'h0085);
        exec(8'h45, 8'h30, 8'h00, 2, 1'b0);
        chk(o_acc, 16'h00c5);
    endtask

    // Pins held apart from the latches so a pin read shows up as a wrong latch value
    task automatic t_port();
        exec(8'h43, 8'h90, 8'h00, 3, 1'b1);
        chk(o_port_latch[1], 16'h00ff);
        exec(8'h45, 8'ha0, 8'h00, 2, 1'b0);
        chk(o_acc, 16'h00d7);
        exec(8'h42, 8'h90, 8'h00, 2, 1'b0);
        chk(o_port_latch[1], 16'h00ff);
    endtask

    task automatic t_back_to_back();
        @(posedge i_ref_clk);
        i_instr <= '{valid: 1'b1, op: 8'h00, b1: 8'h00, b2: 8'h00};
        @(posedge i_ref_clk);
        i_instr <= '{valid: 1'b1, op: 8'h44, b1: 8'h08, b2: 8'h00};
        @(posedge i_ref_clk);
        i_instr.valid <= 1'b0;
        #1;
        exp_pc = exp_pc + 16'h0003;
        chk(o_done, 16'h0001);
        chk(o_pc, exp_pc);
        chk(o_acc, 16'h00df);
    endtask

    // An opcode outside both families is skipped as one byte and flagged
    task automatic t_illegal();
        @(posedge i_ref_clk);
        i_instr <= '{valid: 1'b1, op: 8'h41, b1: 8'h00, b2: 8'h00};
        @(posedge i_ref_clk);
        i_instr.valid <= 1'b0;
        #1;
        exp_pc = exp_pc + 16'h0001;
        chk({o_ready, o_done, o_illegal}, 16'h0007);
        chk(o_pc, exp_pc);
        chk(o_acc, 16'h00df);
    endtask

    // Reset in mid run must clear the counter, accumulator and RAM again
    task automatic t_mid_reset();
        @(posedge i_ref_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        #1;
        exp_pc = 16'h0000;
        t_reset();
        exec(8'h4b, 8'h00, 8'h00, 1, 1'b0);
        chk(o_acc, 16'h0000);
    endtask

    // ---------------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        i_reset_n = 1'b0;
        i_instr = '0;
        i_bank = 2'h1;
        i_port_pins = {8'h00, 8'h12, 8'h00, 8'h00};
        exp_pc = 16'h0000;
        repeat (3) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        #1;
        t_reset();
        t_nop_imm();
        t_bank_reg();
        t_indirect();
        t_direct();
        t_port();
        t_back_to_back();
        t_illegal();
        t_mid_reset();
        test_done();
    end

    // The whole sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge i_ref_clk);
        error_cnt++;
        test_done();
    end

endmodule // nobox_core_bench
